// File: core/dspl_slot_power.sv
// Ten-slot hot-swap drive power sequencer with over-current retry and LEDs.
// Assumes slot pins and controller request lines are asynchronous;
// reset_n is the backplane reset.
`timescale 1ns/1ps
module dspl_slot_power
  import dspl_pkg::*;
#(
  parameter int unsigned PUMP_CYCLES    = PUMP_TICKS,
  parameter int unsigned STAGGER_CYCLES = STAGGER_TICKS,
  parameter int unsigned SLOW_HALF      = SLOW_HALF_TICKS,
  parameter int unsigned FAST_HALF      = FAST_HALF_TICKS
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset_n,
  input  wire dspl_slot_sense_s [NUM_SLOTS-1:0] slotSense,
  output dspl_slot_drive_s      [NUM_SLOTS-1:0] slotDrive,
  output logic                  [NUM_SLOTS-1:0] insertEvent,
  output logic                                   seqBusy
);

  function automatic logic [SLOT_W-1:0] firstSet(
    input logic [NUM_SLOTS-1:0] vec
  );
    logic [SLOT_W-1:0] idx;
    idx = '0;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (vec[k]) begin
        idx = SLOT_W'(k);
      end
    end
    return idx;
  endfunction : firstSet

  // Returns {green, amber}
  function automatic logic [1:0] ledFor(
    input dspl_led_e code,
    input logic      powered,
    input logic      failed,
    input logic      slow,
    input logic      fast
  );
    logic [1:0] ga;
    ga = 2'h0;
    case (code)
      LED_GREEN_ON:    ga = 2'h2;           // R9
      LED_GREEN_BLINK: ga = {fast, 1'b0};   // R9
      LED_AMBER_ON:    ga = 2'h1;           // R10
      LED_AMBER_SLOW:  ga = {1'b0, slow};   // R10
      LED_AMBER_FAST:  ga = {1'b0, fast};   // R11
      LED_OFF:         ga = 2'h0;
      LED_AUTO: begin
        if (failed) begin
          ga = 2'h1;
        end else if (powered) begin
          ga = 2'h2;
        end
      end
      default:         ga = 2'h0;
    endcase
    return ga;
  endfunction : ledFor

  // Two-flop synchronisers for every slot pin and request line
  dspl_slot_sense_s [NUM_SLOTS-1:0] senseMeta;
  dspl_slot_sense_s [NUM_SLOTS-1:0] senseSync;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      // Idle pin levels, so no false insertion follows reset
      senseMeta <= {NUM_SLOTS{SENSE_IDLE}};
      senseSync <= {NUM_SLOTS{SENSE_IDLE}};
    end else begin
      senseMeta <= slotSense;
      senseSync <= senseMeta;
    end
  end

  logic [NUM_SLOTS-1:0] mated;
  logic [NUM_SLOTS-1:0] matedPrev;
  logic [NUM_SLOTS-1:0] want;
  logic [NUM_SLOTS-1:0] oc12;
  logic [NUM_SLOTS-1:0] oc5;

  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      mated[s] = ~senseSync[s].slot_mated_n;                  // R13
      want[s]  = mated[s] & ~senseSync[s].removeRequest;
      oc12[s]  = senseSync[s].overcurrent12;
      oc5[s]   = senseSync[s].overcurrent5;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      matedPrev   <= '0;
      insertEvent <= '0;
    end else begin
      matedPrev   <= mated;
      insertEvent <= mated & ~matedPrev;                      // R1
    end
  end

  // 10 MHz reference tick; every timer below counts these
  logic [2:0] refDivCnt;
  logic       refTick;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refDivCnt <= '0;
      refTick   <= 1'b0;
    end else if (refDivCnt == 3'(REF_DIV - 1)) begin          // R15 R16
      refDivCnt <= '0;
      refTick   <= 1'b1;
    end else begin
      refDivCnt <= refDivCnt + 1'b1;
      refTick   <= 1'b0;
    end
  end

  // Power-up sequencer: one slot at a time, spaced by the stagger interval
  dspl_seq_e         seqState;
  logic [CNT_W-1:0]  seqCnt;
  logic [SLOT_W-1:0] curSlot;
  logic [NUM_SLOTS-1:0] powered;
  logic [NUM_SLOTS-1:0] pending;
  logic [NUM_SLOTS-1:0] pumping;

  assign pending = want & ~powered;

  always_comb begin
    pumping = '0;
    if (seqState == SEQ_PUMP) begin
      pumping[curSlot] = powered[curSlot];                    // R3
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seqState <= SEQ_IDLE;                                   // R14
      seqCnt   <= '0;
      curSlot  <= '0;
    end else begin
      case (seqState)
        SEQ_IDLE: begin
          seqCnt <= '0;
          if (|pending) begin                                 // R7
            curSlot  <= firstSet(pending);
            seqState <= SEQ_PUMP;
          end
        end
        SEQ_PUMP: begin
          if (refTick) begin
            seqCnt <= seqCnt + 1'b1;
            if (seqCnt == CNT_W'(PUMP_CYCLES - 1)) begin      // R3
              seqState <= SEQ_SPACE;
            end
          end
        end
        SEQ_SPACE: begin
          if (refTick) begin
            seqCnt <= seqCnt + 1'b1;
            // One extra tick: tick phase must never shorten the spacing
            if (seqCnt == CNT_W'(STAGGER_CYCLES)) begin       // R7
              seqState <= SEQ_IDLE;
            end
          end
        end
        default: seqState <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      powered <= '0;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (!want[s]) begin
          powered[s] <= 1'b0;
        end else if (seqState == SEQ_IDLE &&
                     firstSet(pending) == SLOT_W'(s) && pending[s]) begin
          powered[s] <= 1'b1;                                 // R1
        end
      end
    end
  end

  // Retry timer and the blanking window that follows each retry
  logic [CNT_W-1:0] retryCnt;
  logic             retryTick;
  logic [CNT_W-1:0] blankCnt;
  logic             blankActive;
  logic             blankEnd;

  assign blankActive = (blankCnt != '0);
  assign blankEnd    = refTick && (blankCnt == CNT_W'(1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      retryCnt  <= '0;
      retryTick <= 1'b0;
    end else begin
      retryTick <= 1'b0;
      if (refTick) begin
        if (retryCnt == CNT_W'(STAGGER_CYCLES - 1)) begin     // R5
          retryCnt  <= '0;
          retryTick <= 1'b1;
        end else begin
          retryCnt <= retryCnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      blankCnt <= '0;
    end else if (retryTick) begin
      blankCnt <= CNT_W'(PUMP_CYCLES);                        // R6
    end else if (refTick && blankActive) begin
      blankCnt <= blankCnt - 1'b1;
    end
  end

  // Over-current trip, per rail; the other rail of the slot is untouched
  logic [NUM_SLOTS-1:0] ocOff12;
  logic [NUM_SLOTS-1:0] ocOff5;
  logic [NUM_SLOTS-1:0] fault12;
  logic [NUM_SLOTS-1:0] fault5;
  logic [NUM_SLOTS-1:0] trip12;
  logic [NUM_SLOTS-1:0] trip5;

  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      trip12[s] = oc12[s] & slotDrive[s].rail12En & ~pumping[s] &
                  ~(blankActive & fault12[s]);                // R6
      trip5[s]  = oc5[s] & slotDrive[s].rail5En & ~pumping[s] &
                  ~(blankActive & fault5[s]);                 // R6
    end
  end

  // Trip beats a same-cycle retry or clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ocOff12 <= '0;
      ocOff5  <= '0;
      fault12 <= '0;
      fault5  <= '0;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (!want[s]) begin                                   // R5
          ocOff12[s] <= 1'b0;
          ocOff5[s]  <= 1'b0;
          fault12[s] <= 1'b0;
          fault5[s]  <= 1'b0;
        end else begin
          if (trip12[s]) begin                                // R4
            ocOff12[s] <= 1'b1;
            fault12[s] <= 1'b1;
          end else if (retryTick) begin                       // R5
            ocOff12[s] <= 1'b0;
          end else if (blankEnd && !ocOff12[s]) begin
            fault12[s] <= 1'b0;
          end
          if (trip5[s]) begin                                 // R4
            ocOff5[s] <= 1'b1;
            fault5[s] <= 1'b1;
          end else if (retryTick) begin                       // R5
            ocOff5[s] <= 1'b0;
          end else if (blankEnd && !ocOff5[s]) begin
            fault5[s] <= 1'b0;
          end
        end
      end
    end
  end

  logic slowPhase;
  logic fastPhase;

  dspl_blink_gen #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) blinkGen (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .refTick   (refTick),
    .slowPhase (slowPhase),
    .fastPhase (fastPhase)
  );

  // All slot drive outputs and seqBusy are registered here; insertEvent is registered above
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slotDrive <= '0;
      seqBusy   <= 1'b0;
    end else begin
      seqBusy <= (seqState != SEQ_IDLE);
      for (int s = 0; s < NUM_SLOTS; s++) begin
        slotDrive[s].rail12En   <= powered[s] & want[s] &
                                   ~ocOff12[s] & ~trip12[s];  // R2
        slotDrive[s].rail5En    <= powered[s] & want[s] &
                                   ~ocOff5[s] & ~trip5[s];    // R2
        slotDrive[s].chargePump <= pumping[s] & want[s];      // R3
        {slotDrive[s].ledGreen, slotDrive[s].ledAmber} <=
          ledFor(senseSync[s].ledRequest, powered[s],         // R8 R12
                 fault12[s] | fault5[s], slowPhase, fastPhase);
      end
    end
  end

  logic [NUM_SLOTS-1:0] pumpOut;

  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      pumpOut[s] = slotDrive[s].chargePump;
    end
  end

  sequence refGap4;
    !refTick [*4];
  endsequence

  a_ref_tick_period: assert property ( // R15
    @(posedge clk_sys) disable iff (!reset_n)
    refTick |=> refGap4 ##1 refTick)
    else $error("Reference tick period is not five cycles");

  a_pump_one_slot: assert property ( // R7
    @(posedge clk_sys) disable iff (!reset_n)
    $onehot0(pumpOut))
    else $error("More than one slot charge pumping");

  a_seq_pump_next: assert property ( // R7
    @(posedge clk_sys) disable iff (!reset_n)
    seqState == SEQ_PUMP |=> seqState inside {SEQ_PUMP, SEQ_SPACE})
    else $error("Pump phase left without stagger spacing");

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : gSlotChk

    sequence retryOn;
      !ocOff12[g] ##1 slotDrive[g].rail12En;
    endsequence

    sequence retryOn5;
      !ocOff5[g] ##1 slotDrive[g].rail5En;
    endsequence

    a_insert_flag: assert property ( // R1
      @(posedge clk_sys) disable iff (!reset_n)
      mated[g] && !matedPrev[g] |=> insertEvent[g])
      else $error("Insertion not flagged");

    a_rail_trip: assert property ( // R4
      @(posedge clk_sys) disable iff (!reset_n)
      trip12[g] && !trip5[g] && slotDrive[g].rail5En && want[g] &&
      !ocOff5[g] |=> !slotDrive[g].rail12En && slotDrive[g].rail5En)
      else $error("Over-current did not cut only the 12 V rail");

    a_retry_enable: assert property ( // R5
      @(posedge clk_sys) disable iff (!reset_n)
      retryTick && ocOff12[g] && want[g] && powered[g] |=> retryOn)
      else $error("Failed rail not retried");

    a_retry_five: assert property ( // R5
      @(posedge clk_sys) disable iff (!reset_n)
      retryTick && ocOff5[g] && want[g] && powered[g] |=> retryOn5)
      else $error("Failed 5 V rail not retried");

    a_pump_blank: assert property ( // R6
      @(posedge clk_sys) disable iff (!reset_n)
      pumping[g] && want[g] |=>
      (!ocOff12[g] || $past(ocOff12[g])) && (!ocOff5[g] || $past(ocOff5[g])))
      else $error("Over-current acted during charge pump");

    a_remove_off: assert property ( // R5
      @(posedge clk_sys) disable iff (!reset_n)
      !want[g] |=> !slotDrive[g].rail12En && !slotDrive[g].rail5En)
      else $error("Rails stayed on after removal");

    a_led_green_on: assert property ( // R9
      @(posedge clk_sys) disable iff (!reset_n)
      senseSync[g].ledRequest == LED_GREEN_ON
      |=> slotDrive[g].ledGreen && !slotDrive[g].ledAmber)
      else $error("Steady green not shown");

    a_led_amber_on: assert property ( // R10
      @(posedge clk_sys) disable iff (!reset_n)
      senseSync[g].ledRequest == LED_AMBER_ON
      |=> slotDrive[g].ledAmber && !slotDrive[g].ledGreen)
      else $error("Steady amber not shown");

    a_led_fast: assert property ( // R11
      @(posedge clk_sys) disable iff (!reset_n)
      senseSync[g].ledRequest == LED_AMBER_FAST
      |=> slotDrive[g].ledAmber == $past(fastPhase) && !slotDrive[g].ledGreen)
      else $error("Fast amber blink wrong");
  end

endmodule : dspl_slot_power

// File: include/dspl_pkg.sv
// Constants, types and encodings for the drive slot power and LED block.
// Assumes a 50 MHz system clock from which a 10 MHz reference tick is made.
// Summary of operation
// R1: On drive detection, flag insertion, power the slot, light its LED.
// R2: Each slot has separate 12 V and 5 V rail switch enables.
// R3: First power-on charge pumps the drive about 700 us.
// R4: Over-current on a rail turns off only that rail of that slot.
// R5: Failed rail retried every third second until fault clears or removal.
// R6: Over-current ignored during a rail's initial power-up period.
// R7: One slot powers up at a time, starts spaced one third second.
// R8: One two-colour LED per slot; colour and blink rate encode state.
// R9: Steady green while initialising, blinking green while active.
// R10: Steady amber on failure; about 1 Hz amber for predict or rebuild.
// R11: About 2.5 Hz amber for interrupted rebuild, empty rebuild, identify.
// R12: Management controllers supply per-slot LED requests on output lines.
// R13: Occupancy comes from a per-slot active-low mated interlock.
// R14: Backplane reset clears all power sequencing timing state.
// R15: All timing derives from the 10 MHz reference rate.
// R16: Pump, stagger, retry and blink times come from counted dividers.
package dspl_pkg;

  localparam int unsigned NUM_SLOTS = 10;
  localparam int unsigned SLOT_W    = 4;
  localparam int unsigned CNT_W     = 23;

  localparam int unsigned CLK_SYS_HZ = 50_000_000;
  localparam int unsigned REF_HZ     = 10_000_000;
  localparam int unsigned REF_DIV    = CLK_SYS_HZ / REF_HZ;

  // Nominal times; counts are in reference ticks
  localparam int unsigned PUMP_TIME_US   = 700;
  localparam int unsigned STAGGER_PER_S  = 3;
  localparam int unsigned SLOW_BLINK_X10 = 10;
  localparam int unsigned FAST_BLINK_X10 = 25;

  localparam int unsigned PUMP_TICKS    = (REF_HZ / 1_000_000) * PUMP_TIME_US;
  localparam int unsigned STAGGER_TICKS = REF_HZ / STAGGER_PER_S;
  localparam int unsigned SLOW_HALF_TICKS = (REF_HZ / 2) * 10 / SLOW_BLINK_X10;
  localparam int unsigned FAST_HALF_TICKS = (REF_HZ / 2) * 10 / FAST_BLINK_X10;

  // Requested LED condition from the management controllers
  typedef enum logic [2:0] {
    LED_AUTO,
    LED_GREEN_ON,
    LED_GREEN_BLINK,
    LED_AMBER_ON,
    LED_AMBER_SLOW,
    LED_AMBER_FAST,
    LED_OFF
  } dspl_led_e;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PUMP,
    SEQ_SPACE
  } dspl_seq_e;

  typedef struct packed {
    logic      slot_mated_n;
    logic      overcurrent12;
    logic      overcurrent5;
    logic      removeRequest;
    dspl_led_e ledRequest;
  } dspl_slot_sense_s;

  // Pin idle levels: slot empty, no fault, no request
  localparam dspl_slot_sense_s SENSE_IDLE = '{
    slot_mated_n:  1'b1,
    overcurrent12: 1'b0,
    overcurrent5:  1'b0,
    removeRequest: 1'b0,
    ledRequest:    LED_AUTO
  };

  typedef struct packed {
    logic rail12En;
    logic rail5En;
    logic chargePump;
    logic ledGreen;
    logic ledAmber;
  } dspl_slot_drive_s;

endpackage : dspl_pkg

// File: core/dspl_blink_gen.sv
// Blink phase generator for the slot LEDs.
// Assumes a one-cycle reference tick enable from the caller.
`timescale 1ns/1ps
module dspl_blink_gen
  import dspl_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_TICKS,
  parameter int unsigned FAST_HALF = FAST_HALF_TICKS
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic refTick,
  output logic      slowPhase,
  output logic      fastPhase
);

  logic [CNT_W-1:0] slowCnt;
  logic [CNT_W-1:0] fastCnt;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slowCnt   <= '0;
      slowPhase <= 1'b0;
    end else if (refTick) begin
      if (slowCnt == CNT_W'(SLOW_HALF - 1)) begin // R10 R16
        slowCnt   <= '0;
        slowPhase <= ~slowPhase;
      end else begin
        slowCnt <= slowCnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fastCnt   <= '0;
      fastPhase <= 1'b0;
    end else if (refTick) begin
      if (fastCnt == CNT_W'(FAST_HALF - 1)) begin // R11 R16
        fastCnt   <= '0;
        fastPhase <= ~fastPhase;
      end else begin
        fastCnt <= fastCnt + 1'b1;
      end
    end
  end

endmodule : dspl_blink_gen

// File: tb/dspl_far_model.sv
// Far side model: management controllers and per-slot rail switch sensing.
// Assumes the bench drives its control inputs at the falling clock edge.
`timescale 1ns/1ps
module dspl_far_model
  import dspl_pkg::*;
(
  input  wire logic             [NUM_SLOTS-1:0] matedN,
  input  wire logic             [NUM_SLOTS-1:0] removeReq,
  input  wire logic             [NUM_SLOTS-1:0] short12,
  input  wire logic             [NUM_SLOTS-1:0] short5,
  input  wire dspl_led_e        [NUM_SLOTS-1:0] ledReq,
  input  wire dspl_slot_drive_s [NUM_SLOTS-1:0] slotDrive,
  output dspl_slot_sense_s      [NUM_SLOTS-1:0] slotSense
);
  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      slotSense[s].slot_mated_n  = matedN[s];
      // A short only reads as over-current while its switch conducts
      slotSense[s].overcurrent12 = short12[s] & slotDrive[s].rail12En;
      slotSense[s].overcurrent5  = short5[s] & slotDrive[s].rail5En;
      slotSense[s].removeRequest = removeReq[s];
      slotSense[s].ledRequest    = ledReq[s];
    end
  end
endmodule : dspl_far_model

// File: tb/dspl_slot_power_bench.sv
// Self-checking bench for the slot power sequencer with shortened counts.
// Assumes the far side model and the package are compiled first.
`timescale 1ns/1ps
module dspl_slot_power_bench;
  import dspl_pkg::*;
  localparam int PUMP_P = 10;
  localparam int STAG_P = 40;
  localparam int SLOW_P = 8;
  localparam int FAST_P = 4;
  localparam int PUMP_CLK = PUMP_P * REF_DIV;
  localparam int STAG_CLK = STAG_P * REF_DIV;
  localparam int WIN = 400;
  localparam int SEL_INS = 0;
  localparam int SEL_R12 = 1;
  localparam int SEL_R5 = 2;
  localparam int SEL_PUMP = 3;
  localparam int SEL_BUSY = 4;

  logic                             clk_sys;
  logic                             reset_n;
  dspl_slot_sense_s [NUM_SLOTS-1:0] slotSense;
  dspl_slot_drive_s [NUM_SLOTS-1:0] slotDrive;
  logic             [NUM_SLOTS-1:0] insertEvent;
  logic                             seqBusy;
  logic             [NUM_SLOTS-1:0] matedN;
  logic             [NUM_SLOTS-1:0] removeReq;
  logic             [NUM_SLOTS-1:0] short12;
  logic             [NUM_SLOTS-1:0] short5;
  dspl_led_e        [NUM_SLOTS-1:0] ledReq;
  int                               errTotal;
  int                               numChecks;

  dspl_slot_power #(
    .PUMP_CYCLES    (PUMP_P),
    .STAGGER_CYCLES (STAG_P),
    .SLOW_HALF      (SLOW_P),
    .FAST_HALF      (FAST_P)
  ) dut_u (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .slotSense   (slotSense),
    .slotDrive   (slotDrive),
    .insertEvent (insertEvent),
    .seqBusy     (seqBusy)
  );

  dspl_far_model far_u (
    .matedN    (matedN),
    .removeReq (removeReq),
    .short12   (short12),
    .short5    (short5),
    .ledReq    (ledReq),
    .slotDrive (slotDrive),
    .slotSense (slotSense)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic endSim;
    $display("Checks %0d, mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : endSim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string m);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  function automatic logic sig(input int s, input int sel);
    case (sel)
      SEL_INS: return insertEvent[s];
      SEL_R12: return slotDrive[s].rail12En;
      SEL_R5: return slotDrive[s].rail5En;
      SEL_PUMP: return slotDrive[s].chargePump;
      default: return seqBusy;
    endcase
  endfunction : sig

  // Bounded wait; running out ends the run as a mismatch
  task automatic waitSig(input int s, input int sel, input logic v,
                         input int lim, output int n);
    n = 0;
    while (sig(s, sel) !== v) begin
      if (n >= lim) begin
        errTotal++;
        $display("Error at %0t: wait ran out, slot %0d sel %0d", $time, s, sel);
        endSim();
      end
      @(negedge clk_sys);
      n++;
    end
  endtask : waitSig

  task automatic testInsert;
    int n;
    matedN[3] = 1'b0;
    waitSig(3, SEL_INS, 1'b1, 10, n);
    check(n >= 3 && n <= 5, 1, "insert latency");
    cyc(1);
    check(insertEvent[3], 1'b0, "insert pulse width");
    waitSig(3, SEL_PUMP, 1'b1, 5, n);
    check(slotDrive[3].rail12En, 1'b1, "12V on");
    check(slotDrive[3].rail5En, 1'b1, "5V on");
    check(seqBusy, 1'b1, "busy while pumping");
    waitSig(3, SEL_PUMP, 1'b0, PUMP_CLK + 10, n);
    check(n >= PUMP_CLK - REF_DIV && n <= PUMP_CLK + REF_DIV,
          1, "pump");
    check({slotDrive[3].rail12En, slotDrive[3].rail5En}, 2'b11, "rails");
    cyc(3);
    check({slotDrive[3].ledGreen, slotDrive[3].ledAmber}, 2'b10,
          "init");
    waitSig(0, SEL_BUSY, 1'b0, STAG_CLK, n);
    $display("test insert done");
  endtask : testInsert

  task automatic testStagger;
    int t1;
    int t6;
    int both;
    t1 = -1;
    t6 = -1;
    both = 0;
    matedN[1] = 1'b0;
    matedN[6] = 1'b0;
    for (int c = 0; c < 2 * STAG_CLK + 40; c++) begin
      @(negedge clk_sys);
      if (t1 < 0 && slotDrive[1].chargePump === 1'b1) t1 = c;
      if (t6 < 0 && slotDrive[6].chargePump === 1'b1) t6 = c;
      if (slotDrive[1].chargePump === 1'b1 && slotDrive[6].chargePump === 1'b1)
        both++;
    end
    check(both, 0, "overlapping power-up");
    check(t1 >= 0 && t6 > t1, 1, "start order");
    check(t6 - t1 >= STAG_CLK && t6 - t1 <= STAG_CLK + 20, 1, "spacing");
    $display("test stagger done");
  endtask : testStagger

  task automatic testFaultRetry;
    int n;
    int hold;
    int off;
    waitSig(0, SEL_BUSY, 1'b0, 2 * STAG_CLK, n);
    short5[8] = 1'b1;
    matedN[8] = 1'b0;
    waitSig(8, SEL_PUMP, 1'b1, 12, n);
    off = 0;
    for (int c = 0; c < PUMP_CLK - REF_DIV; c++) begin
      if (slotDrive[8].rail5En !== 1'b1) off++;
      @(negedge clk_sys);
    end
    check(off, 0, "trip during inrush");
    waitSig(8, SEL_R5, 1'b0, 2 * REF_DIV + 6, n);
    check(slotDrive[8].rail12En, 1'b1, "healthy rail kept");
    cyc(3);
    check({slotDrive[8].ledGreen, slotDrive[8].ledAmber}, 2'b01,
          "fail");
    waitSig(8, SEL_R5, 1'b1, STAG_CLK + 10, n);
    waitSig(8, SEL_R5, 1'b0, PUMP_CLK + 10, hold);
    check(hold >= PUMP_CLK - REF_DIV && hold <= PUMP_CLK + 8,
          1, "blank");
    waitSig(8, SEL_R5, 1'b1, STAG_CLK + 10, n);
    check(n + hold >= STAG_CLK - 2 && n + hold <= STAG_CLK + 2,
          1, "retry");
    short5[8] = 1'b0;
    off = 0;
    repeat (STAG_CLK + 20) begin
      @(negedge clk_sys);
      if (slotDrive[8].rail5En !== 1'b1) off++;
    end
    check(off, 0, "rail after fault clears");
    check({slotDrive[8].ledGreen, slotDrive[8].ledAmber}, 2'b10, "ok");
    matedN[8] = 1'b1;
    waitSig(8, SEL_R12, 1'b0, 6, n);
    $display("test fault retry done");
  endtask : testFaultRetry

  task automatic testRemove;
    int n;
    int on;
    short12[3] = 1'b1;
    waitSig(3, SEL_R12, 1'b0, 6, n);
    check(slotDrive[3].rail5En, 1'b1, "other rail kept");
    removeReq[3] = 1'b1;
    waitSig(3, SEL_R5, 1'b0, 6, n);
    on = 0;
    repeat (STAG_CLK + 20) begin
      @(negedge clk_sys);
      if (slotDrive[3].rail12En !== 1'b0) on++;
    end
    check(on, 0, "retry after removal");
    removeReq[3] = 1'b0;
    short12[3] = 1'b0;
    matedN[3] = 1'b1;
    $display("test remove done");
  endtask : testRemove

  // Kind: 0 dark, 1 steady, else half period in reference ticks
  function automatic logic expOk(input int k, input int hi, input int tg);
    case (k)
      0: return hi == 0 && tg == 0;
      1: return hi == WIN && tg == 0;
      default: return tg >= WIN / (k * REF_DIV) - 1 &&
                      tg <= WIN / (k * REF_DIV) + 1;
    endcase
  endfunction : expOk

  task automatic testLed;
    int gK[8];
    int aK[8];
    int gh, ah, gt, at;
    logic pg, pa;
    gK = '{0, 1, FAST_P, 0, 0, 0, 0, 0};
    aK = '{0, 0, 0, 1, SLOW_P, FAST_P, 0, 0};
    for (int c = 0; c < 8; c++) begin
      ledReq[0] = dspl_led_e'(c);
      cyc(6);
      {gh, ah, gt, at} = '0;
      pg = slotDrive[0].ledGreen;
      pa = slotDrive[0].ledAmber;
      repeat (WIN) begin
        @(negedge clk_sys);
        if (slotDrive[0].ledGreen === 1'b1) gh++;
        if (slotDrive[0].ledAmber === 1'b1) ah++;
        if (slotDrive[0].ledGreen !== pg) gt++;
        if (slotDrive[0].ledAmber !== pa) at++;
        pg = slotDrive[0].ledGreen;
        pa = slotDrive[0].ledAmber;
      end
      check(expOk(gK[c], gh, gt), 1'b1, "green pattern");
      check(expOk(aK[c], ah, at), 1'b1, "amber pattern");
    end
    ledReq[0] = LED_AUTO;
    $display("test led done");
  endtask : testLed

  task automatic testReset;
    int n;
    matedN[2] = 1'b0;
    waitSig(2, SEL_PUMP, 1'b1, STAG_CLK + 20, n);
    reset_n = 1'b0;
    cyc(1);
    check(slotDrive[2], 0, "drive in reset");
    check(seqBusy, 1'b0, "busy in reset");
    reset_n = 1'b1;
    cyc(1);
    check(slotDrive[2], 0, "drive after release");
    check(insertEvent, 0, "insert after release");
    $display("test reset done");
  endtask : testReset

  initial begin
    errTotal = 0;
    numChecks = 0;
    reset_n = 1'b0;
    matedN = '1;
    removeReq = '0;
    short12 = '0;
    short5 = '0;
    ledReq = {NUM_SLOTS{LED_AUTO}};
    cyc(4);
    reset_n = 1'b1;
    cyc(2);
    testInsert();
    testStagger();
    testFaultRetry();
    testRemove();
    testLed();
    testReset();
    endSim();
  end
endmodule : dspl_slot_power_bench
